// [core/vpic_cfg.svh]
// register map, field positions, reset values and sizes of the interrupt controller
`ifndef VPIC_CFG_SVH
`define VPIC_CFG_SVH

`define VPIC_NUM_PERIPH 8
`define VPIC_NUM_SRC 9
`define VPIC_SRC_EXT_STD 8
`define VPIC_PRIO_W 3
`define VPIC_VEC_W 4
`define VPIC_WIN_BITS 14
`define VPIC_BASE_HI 18'h3FFFF
`define VPIC_BASE_SEL 2'h0

`define VPIC_ENA_SET 12'h000
`define VPIC_ENA_CLR 12'h004
`define VPIC_ENA_RD 12'h008
`define VPIC_EDGE_SET 12'h010
`define VPIC_EDGE_CLR 12'h014
`define VPIC_EDGE_RD 12'h018
`define VPIC_PEND_CLR 12'h024
`define VPIC_PEND_RD 12'h028
`define VPIC_PRIO0 12'h040
`define VPIC_EXTMODE 12'h080
`define VPIC_VECTOR 12'h084
`define VPIC_EOI 12'h088
`define VPIC_RAW 12'h08C
`define VPIC_IRQ_STAT 12'h090
`define VPIC_IRQ_MASK 12'h094

`define VPIC_VEC_NONE 4'hF
`define VPIC_FAST_MODE_POS 2
`define VPIC_STD_MODE_POS 0
`define VPIC_EV_ACK 0
`define VPIC_EV_FAST 1
`define VPIC_EV_W 2
`define VPIC_ENA_RST 9'h000
`define VPIC_EDGE_RST 9'h000
`define VPIC_EXTMODE_RST 4'h0

`endif

// [core/vpic_pkg.sv]
// types shared by the interrupt controller files
package vpic_pkg;
   typedef enum logic [1:0]
   {
      VPIC_SENSE_LOW,
      VPIC_SENSE_HIGH,
      VPIC_SENSE_FALL,
      VPIC_SENSE_RISE
   } vpic_sense_t;

   typedef enum
   {
      VPIC_IDLE,
      VPIC_ACK
   } vpic_bus_st_t;
endpackage

// [core/vpic_sense.sv]
// one synchronised external request line with four sense modes
`timescale 1ns/1ps
`include "vpic_cfg.svh"

module vpic_sense
(
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // pin and mode
   input wire logic pin_i,
   input wire logic [1:0] mode_i,
   input wire logic clr_i,
   // result
   output logic pend_o
);
   logic meta_r;
   logic sync_r;
   logic prev_r;
   logic latch_r;
   logic rise;
   logic fall;
   vpic_pkg::vpic_sense_t mode;

   ////////////////////////////////////////////////////////////////////////
   // no reset: the reset cycles fill the chain with the pin level, so an
   // idle-high pin shows no false edge or level on release
   always_ff @(posedge clk_i)
   begin
      meta_r <= pin_i;
      sync_r <= meta_r;
      prev_r <= sync_r;
   end

   assign mode = vpic_pkg::vpic_sense_t'(mode_i);
   assign rise = sync_r & ~prev_r;
   assign fall = ~sync_r & prev_r;

   // set wins over a clear in the same cycle
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         latch_r <= 1'b0;
      else if ((mode == vpic_pkg::VPIC_SENSE_RISE && rise) ||
               (mode == vpic_pkg::VPIC_SENSE_FALL && fall))
         latch_r <= 1'b1;
      else if (clr_i)
         latch_r <= 1'b0;
   end

   always_comb
   begin
      case (mode)
         vpic_pkg::VPIC_SENSE_LOW: pend_o = ~sync_r;
         vpic_pkg::VPIC_SENSE_HIGH: pend_o = sync_r;
         default: pend_o = latch_r;
      endcase
   end
endmodule

// [core/vpic_top.sv]
// vectored eight-level priority interrupt controller with wishbone slave
//
// Added by the designer: the address map and register access over Wishbone.
`timescale 1ns/1ps
`include "vpic_cfg.svh"

module vpic_top
(
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // wishbone slave
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic we_i,
   input wire logic [31:0] adr_i,
   input wire logic [3:0] sel_i,
   input wire logic [31:0] dat_i,
   output logic [31:0] dat_o,
   output logic ack_o,
   // request sources
   input wire logic [7:0] periph_irq_i,
   input wire logic ext_standard_request_pin_i,
   input wire logic ext_fast_request_pin_i,
   // core request lines
   output logic core_fast_request_n_o,
   output logic core_standard_request_n_o,
   output logic [3:0] vector_o,
   // controller interrupt
   output logic irq_o
);
   localparam int NS = `VPIC_NUM_SRC;
   localparam int NP = `VPIC_NUM_PERIPH;

   vpic_pkg::vpic_bus_st_t bus_st_r;
   logic [NS-1:0] ena_r;
   logic [NS-1:0] edge_r;
   logic [NP-1:0] plat_r;
   logic [NP-1:0] prev_r;
   logic [2:0] prio_r [NS];
   logic [3:0] extmode_r;
   logic [3:0] vec_r;
   logic [3:0] vec_nxt;
   logic fast_r;
   logic std_r;
   logic [`VPIC_EV_W-1:0] ev_stat_r;
   logic [`VPIC_EV_W-1:0] ev_mask_r;
   logic [`VPIC_EV_W-1:0] ev_set;
   logic [NS-1:0] pend;
   logic [NS-1:0] act;
   logic [NP-1:0] pclr;
   logic ext_std_pend;
   logic ext_fast_pend;
   logic ext_std_clr;
   logic hit;
   logic wr;
   logic rd_en;
   logic [11:0] off;
   logic [31:0] wdat;
   logic [31:0] rdat;
   logic fast_prev_r;

   ////////////////////////////////////////////////////////////////////////
   // bus decode
   function automatic logic is_off(input logic [11:0] a, input logic [11:0] b);
      return a == b;
   endfunction

   // byte enables gate the written bits
   function automatic logic [31:0] lane(input logic [31:0] d,
                                        input logic [3:0] s);
      return d & {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
   endfunction

   // window is the top 16 KB of the address space; base is the window, not its lowest
   // register, so map offsets need not start at zero
   assign hit = cyc_i && stb_i && adr_i[31:14] == `VPIC_BASE_HI;
   assign off = {adr_i[11:2], 2'b00};
   assign wdat = lane(dat_i, sel_i);
   assign wr = hit && we_i && bus_st_r == vpic_pkg::VPIC_IDLE;
   assign rd_en = hit && !we_i && bus_st_r == vpic_pkg::VPIC_IDLE;

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         bus_st_r <= vpic_pkg::VPIC_IDLE;
      else
      begin
         case (bus_st_r)
            vpic_pkg::VPIC_IDLE:
               if (cyc_i && stb_i)
                  bus_st_r <= vpic_pkg::VPIC_ACK;
            vpic_pkg::VPIC_ACK:
               bus_st_r <= vpic_pkg::VPIC_IDLE;
            default:
               bus_st_r <= vpic_pkg::VPIC_IDLE;
         endcase
      end
   end

   // unmapped addresses still get ack and read as zero
   assign ack_o = bus_st_r == vpic_pkg::VPIC_ACK;

   ////////////////////////////////////////////////////////////////////////
   // set / clear / read registers
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         ena_r <= `VPIC_ENA_RST;
      else if (wr && is_off(off, `VPIC_ENA_SET))
         ena_r <= ena_r | wdat[NS-1:0];
      else if (wr && is_off(off, `VPIC_ENA_CLR))
         ena_r <= ena_r & ~wdat[NS-1:0];
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         edge_r <= `VPIC_EDGE_RST;
      else if (wr && is_off(off, `VPIC_EDGE_SET))
         edge_r <= edge_r | wdat[NS-1:0];
      else if (wr && is_off(off, `VPIC_EDGE_CLR))
         edge_r <= edge_r & ~wdat[NS-1:0];
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         extmode_r <= `VPIC_EXTMODE_RST;
      else if (wr && is_off(off, `VPIC_EXTMODE))
         extmode_r <= wdat[3:0];
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         for (int i = 0; i < NS; i++)
            prio_r[i] <= 3'h0;
      end
      else
      begin
         for (int i = 0; i < NS; i++)
            if (wr && off == `VPIC_PRIO0 + 12'(4 * i))
               prio_r[i] <= wdat[2:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // peripheral sensing; peripherals are on this clock, so no synchroniser
   // end of interrupt clears the edge latch of the source being serviced
   always_comb
   begin
      pclr = '0;
      for (int i = 0; i < NP; i++)
         pclr[i] = (wr && is_off(off, `VPIC_PEND_CLR) && wdat[i]) ||
                   (wr && is_off(off, `VPIC_EOI) && vec_r == 4'(i));
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         prev_r <= '0;
      else
         prev_r <= periph_irq_i;
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         plat_r <= '0;
      else
      begin
         // level sources keep no stale latch for a later switch to edge
         for (int i = 0; i < NP; i++)
            if (edge_r[i] && periph_irq_i[i] && !prev_r[i])
               plat_r[i] <= 1'b1;
            else if (pclr[i] || !edge_r[i])
               plat_r[i] <= 1'b0;
      end
   end

   assign ext_std_clr = (wr && is_off(off, `VPIC_PEND_CLR) &&
                         wdat[`VPIC_SRC_EXT_STD]) ||
                        (wr && is_off(off, `VPIC_EOI) &&
                         vec_r == 4'(`VPIC_SRC_EXT_STD));

   vpic_sense u_std_sense
   (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .pin_i(ext_standard_request_pin_i),
      .mode_i(extmode_r[`VPIC_STD_MODE_POS +: 2]),
      .clr_i(ext_std_clr),
      .pend_o(ext_std_pend)
   );

   vpic_sense u_fast_sense
   (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .pin_i(ext_fast_request_pin_i),
      .mode_i(extmode_r[`VPIC_FAST_MODE_POS +: 2]),
      .clr_i(wr && is_off(off, `VPIC_PEND_CLR) && wdat[NS]),
      .pend_o(ext_fast_pend)
   );

   always_comb
   begin
      for (int i = 0; i < NP; i++)
         pend[i] = edge_r[i] ? plat_r[i] : periph_irq_i[i];
      pend[`VPIC_SRC_EXT_STD] = ext_std_pend;
   end

   assign act = pend & ena_r;

   ////////////////////////////////////////////////////////////////////////
   // priority encoder: strict greater keeps the lowest index on ties
   always_comb
   begin
      logic [2:0] best;
      logic found;
      best = 3'h0;
      found = 1'b0;
      vec_nxt = `VPIC_VEC_NONE;
      for (int i = 0; i < NS; i++)
         if (act[i] && (!found || prio_r[i] > best))
         begin
            best = prio_r[i];
            found = 1'b1;
            vec_nxt = 4'(i);
         end
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         vec_r <= `VPIC_VEC_NONE;
         std_r <= 1'b0;
      end
      else
      begin
         vec_r <= vec_nxt;
         std_r <= |act;
      end
   end

   // fast line: external pin only, not maskable
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         fast_r <= 1'b0;
      else
         fast_r <= ext_fast_pend;
   end

   assign core_fast_request_n_o = ~fast_r;
   assign core_standard_request_n_o = ~std_r;
   assign vector_o = vec_r;

   ////////////////////////////////////////////////////////////////////////
   // controller events: vector acknowledged, fast request seen
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         fast_prev_r <= 1'b0;
      else
         fast_prev_r <= fast_r;
   end

   always_comb
   begin
      ev_set = '0;
      ev_set[`VPIC_EV_ACK] = wr && is_off(off, `VPIC_EOI);
      ev_set[`VPIC_EV_FAST] = fast_r && !fast_prev_r;
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         ev_stat_r <= '0;
      else if (wr && is_off(off, `VPIC_IRQ_STAT))
         ev_stat_r <= ev_set | (ev_stat_r & ~wdat[`VPIC_EV_W-1:0]);
      else
         ev_stat_r <= ev_stat_r | ev_set;
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         ev_mask_r <= '0;
      else if (wr && is_off(off, `VPIC_IRQ_MASK))
         ev_mask_r <= wdat[`VPIC_EV_W-1:0];
   end

   assign irq_o = |(ev_stat_r & ev_mask_r);

   ////////////////////////////////////////////////////////////////////////
   // read data
   always_comb
   begin
      rdat = '0;
      case (off)
         `VPIC_ENA_RD: rdat[NS-1:0] = ena_r;
         `VPIC_EDGE_RD: rdat[NS-1:0] = edge_r;
         `VPIC_PEND_RD:
         begin
            rdat[NS-1:0] = pend;
            rdat[NS] = ext_fast_pend;
         end
         `VPIC_EXTMODE: rdat[3:0] = extmode_r;
         `VPIC_VECTOR: rdat[3:0] = vec_r;
         `VPIC_RAW: rdat[NP-1:0] = periph_irq_i;
         `VPIC_IRQ_STAT: rdat[`VPIC_EV_W-1:0] = ev_stat_r;
         `VPIC_IRQ_MASK: rdat[`VPIC_EV_W-1:0] = ev_mask_r;
         default:
         begin
            for (int i = 0; i < NS; i++)
               if (off == `VPIC_PRIO0 + 12'(4 * i))
                  rdat[2:0] = prio_r[i];
         end
      endcase
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         dat_o <= '0;
      else if (rd_en)
         dat_o <= rdat;
      else if (ack_o)
         dat_o <= '0;
   end
endmodule

// [dv/test_vpic_top.sv]
// self-checking bench for the interrupt controller
`timescale 1ns/1ps
`include "vpic_cfg.svh"
module test_vpic_top;
   logic [31:0] base_adr = 32'hFFFF_C000;
   logic clk_i, rst_i, cyc, stb, we, ack, fast_n, std_n, irq;
   logic std_pin, fast_pin;
   logic [31:0] adr, wdat, rdat, q, seed;
   logic [9:0] want;
   logic [7:0] per;
   logic [3:0] vec;
   logic [8:0] ena;
   logic [2:0] pr [8];
   int err_total, n_compared, i, m, r;
   vpic_src_model i_vpic_src_model (.want_i(want), .periph_o(per),
      .std_pin_o(std_pin), .fast_pin_o(fast_pin));
   vpic_top i_vpic_top (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc),
      .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(4'hF), .dat_i(wdat),
      .dat_o(rdat), .ack_o(ack), .periph_irq_i(per),
      .ext_standard_request_pin_i(std_pin),
      .ext_fast_request_pin_i(fast_pin), .core_fast_request_n_o(fast_n),
      .core_standard_request_n_o(std_n), .vector_o(vec), .irq_o(irq));
   ////////////////////////////////////////////////////////////
   function automatic logic [31:0] xs(input logic [31:0] s);
      s ^= s << 13;
      s ^= s >> 17;
      return s ^ (s << 5);
   endfunction
   // scan downward with >= so the lowest index wins a tie
   function automatic logic [3:0] win(input logic [7:0] p);
      logic [3:0] b;
      b = `VPIC_VEC_NONE;
      for (int k = 7; k >= 0; k--)
         if (p[k] && (b == 4'hF || pr[k] >= pr[b[2:0]]))
            b = k[3:0];
      return b;
   endfunction
   task automatic chk(input string nm, input logic [31:0] e, g);
      n_compared++;
      if (g !== e)
      begin
         err_total++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic wb(input logic w, input logic [31:0] a, d);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      do
      begin
         @(posedge clk_i);
      end
      while (ack !== 1'b1);
      q = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
      @(posedge clk_i);
   endtask
   task automatic wr(input logic [11:0] o, input logic [31:0] d);
      wb(1'b1, {base_adr[31:12], o}, d);
   endtask
   task automatic rd(input logic [11:0] o);
      wb(1'b0, {base_adr[31:12], o}, 32'h0);
   endtask
   task automatic tick(input int k);
      repeat (k) @(posedge clk_i);
   endtask
   task automatic wrap_up();
      $display("compared %0d errors %0d", n_compared, err_total);
      if (err_total == 0 && n_compared > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////
   initial
   begin
      clk_i = 1'b0;
      forever #5 clk_i = ~clk_i;
   end
   initial
   begin
      repeat (20000) @(posedge clk_i);
      err_total++;
      wrap_up();
   end
   initial
   begin
      {rst_i, cyc, stb, we, adr, wdat} <= {4'h8, 64'h0};
      want <= 10'h300;
      seed = 32'd75747;
      ena = 9'h0;
      tick(10);
      rst_i <= 1'b0;
      tick(2);
      chk("vector", 4'hF, vec);
      rd(`VPIC_EDGE_RD);
      chk("edge", 32'h0, q);
      for (i = 0; i < 6; i++)
      begin
         seed = xs(seed);
         wr(`VPIC_ENA_SET, seed[8:0]);
         ena |= seed[8:0];
         wr(`VPIC_ENA_CLR, seed[20:12]);
         ena &= ~seed[20:12];
         rd(`VPIC_ENA_RD);
         chk("enable", ena, q);
      end
      wb(1'b1, 32'h0FFF_C000, 32'h1FF);
      rd(`VPIC_ENA_RD);
      chk("enable", ena, q);
      wb(1'b0, 32'h0FFF_C008, 32'h0);
      chk("outside", 32'h0, q);
      wr(`VPIC_ENA_SET, 32'hFF);
      for (r = 0; r < 4; r++)
      begin
         seed = xs(seed);
         for (i = 0; i < 8; i++)
         begin
            pr[i] = (r == 3) ? 3'h5 : seed[3*i+:3];
            wr(`VPIC_PRIO0 + 12'(4*i), pr[i]);
         end
         want[7:0] <= seed[31:24] | ((r == 3) ? 8'hFF : 8'h0);
         tick(3);
         chk("vector", win(want[7:0]), vec);
         chk("fast", 1'b1, fast_n);
      end
      wr(`VPIC_ENA_CLR, 32'h1);
      tick(2);
      chk("masked", win(8'hFE), vec);
      want[7:0] <= 8'h0;
      wr(`VPIC_ENA_CLR, 32'h1FF);
      wr(`VPIC_ENA_SET, 32'h8);
      wr(`VPIC_EDGE_SET, 32'h8);
      chk("edge idle", 1'b1, std_n);
      want[3] <= 1'b1;
      tick(1);
      want[3] <= 1'b0;
      tick(3);
      chk("latched", 4'h3, vec);
      rd(`VPIC_PEND_RD);
      chk("pend", 32'h8, q);
      rd(`VPIC_VECTOR);
      chk("vector reg", 32'h3, q);
      wr(`VPIC_PEND_CLR, 32'h8);
      tick(2);
      chk("cleared", 1'b1, std_n);
      wr(`VPIC_EDGE_CLR, 32'h8);
      want[3] <= 1'b1;
      tick(3);
      chk("level", 1'b0, std_n);
      want[3] <= 1'b0;
      tick(3);
      chk("level", 1'b1, std_n);
      wr(`VPIC_ENA_CLR, 32'h1FF);
      wr(`VPIC_ENA_SET, 32'h100);
      for (m = 0; m < 4; m++)
      begin
         want[8] <= ~m[0];
         tick(4);
         wr(`VPIC_EXTMODE, m);
         wr(`VPIC_PEND_CLR, 32'h100);
         tick(5);
         chk("pin idle", 1'b1, std_n);
         want[8] <= m[0];
         tick(5);
         chk("pin vector", 4'h8, vec);
         want[8] <= ~m[0];
         tick(5);
         chk("pin after", !m[1], std_n);
         wr(`VPIC_EOI, 32'h0);
         tick(2);
         chk("eoi clear", 1'b1, std_n);
      end
      wr(`VPIC_ENA_CLR, 32'h1FF);
      want <= 10'h0FF;
      wr(`VPIC_EXTMODE, 32'hC);
      wr(`VPIC_IRQ_STAT, 32'h3);
      wr(`VPIC_IRQ_MASK, 32'h2);
      tick(5);
      chk("fast idle", 1'b1, fast_n);
      want[9] <= 1'b1;
      tick(6);
      chk("fast", 1'b0, fast_n);
      chk("irq fast", 1'b1, irq);
      wr(`VPIC_PEND_CLR, 32'h200);
      tick(2);
      chk("fast clr", 1'b1, fast_n);
      wr(`VPIC_IRQ_MASK, 32'h1);
      chk("irq mask", 1'b0, irq);
      wr(`VPIC_EOI, 32'h0);
      tick(2);
      chk("irq eoi", 1'b1, irq);
      wr(`VPIC_IRQ_STAT, 32'h3);
      chk("irq clr", 1'b0, irq);
      wrap_up();
   end
endmodule
bind vpic_top vpic_checker i_vpic_checker (.clk_i(clk_i), .rst_i(rst_i),
   .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
   .dat_o(dat_o), .ack_o(ack_o),
   .ext_fast_request_pin_i(ext_fast_request_pin_i),
   .core_fast_request_n_o(core_fast_request_n_o),
   .core_standard_request_n_o(core_standard_request_n_o),
   .vector_o(vector_o));

// [dv/vpic_checker.sv]
// port assertions for the interrupt controller
`timescale 1ns/1ps
`include "vpic_cfg.svh"
module vpic_checker
(
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // bus
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic we_i,
   input wire logic [31:0] adr_i,
   input wire logic [31:0] dat_o,
   input wire logic ack_o,
   // requests
   input wire logic ext_fast_request_pin_i,
   input wire logic core_fast_request_n_o,
   input wire logic core_standard_request_n_o,
   input wire logic [3:0] vector_o
);
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);
   ////////////////////////////////////////////////////////////
   sequence req_seen;
      $rose(cyc_i && stb_i);
   endsequence
   // six quiet cycles cover sync, edge stage and a late mode write
   sequence quiet_fast;
      (!cyc_i && $stable(ext_fast_request_pin_i))[*6];
   endsequence
   sequence rd_ack;
      ack_o && !we_i;
   endsequence
   chk_ack_after_req: assert property (req_seen |=> ack_o)
      else $error("ack missing after request");
   chk_ack_one_cycle: assert property (ack_o |=> !ack_o)
      else $error("ack longer than one cycle");
   chk_data_idle_zero: assert property (!ack_o |-> dat_o == 32'h0)
      else $error("read data outside ack");
   chk_fast_pin_only: assert property (quiet_fast |->
      $stable(core_fast_request_n_o))
      else $error("fast request moved without its pin");
   chk_std_vec_agree: assert property
      (core_standard_request_n_o == (vector_o == `VPIC_VEC_NONE))
      else $error("standard request and vector disagree");
   chk_vector_range: assert property
      (vector_o <= 4'h8 || vector_o == `VPIC_VEC_NONE)
      else $error("vector names no source");
   chk_out_window: assert property (rd_ack and
      adr_i[31:14] != `VPIC_BASE_HI |-> dat_o == 32'h0)
      else $error("read outside window not zero");
   chk_enable_width: assert property (rd_ack and
      adr_i[11:0] == `VPIC_ENA_RD |-> dat_o[31:9] == 23'h0)
      else $error("enable read upper bits set");
endmodule

// [dv/vpic_src_model.sv]
// peripheral lines and request pins facing the controller
`timescale 1ns/1ps
module vpic_src_model
(
   // wanted levels, fast pin on top
   input wire logic [9:0] want_i,
   // source lines
   output logic [7:0] periph_o,
   output logic std_pin_o,
   output logic fast_pin_o
);
   // pins are asynchronous, so they follow the wish at once
   assign {fast_pin_o, std_pin_o, periph_o} = want_i;
endmodule
